// >>> shared/shift_right_ext_consts.vh
// constants for the right-shift datapath: opcodes, fields, offsets, resets
`ifndef SHIFT_RIGHT_EXT_CONSTS_VH
`define SHIFT_RIGHT_EXT_CONSTS_VH

// primary and extended opcodes
`define PRIMARY_OPC_SHIFTS   6'h1f
`define EXT_OPC_DWORD_SRL    10'h21b
`define EXT_OPC_EXT_PLAIN    10'h299
`define EXT_OPC_EXT_ALG      10'h399
`define EXT_OPC_EXT_MERGE    10'h2d9

// instruction field positions, lsb-first numbering of a 32-bit word
`define FLD_PRIMARY_HI       31
`define FLD_PRIMARY_LO       26
`define FLD_TARGET_HI        20
`define FLD_TARGET_LO        16
`define FLD_EXT_OPC_HI       10
`define FLD_EXT_OPC_LO       1
`define FLD_RECORD           0

// shift amount fields inside the shift-amount operand, and the source word sign bit
`define AMT7_HI              6
`define AMT6_HI              5
`define AMT5_HI              4
`define WORD_SIGN_BIT        31

// register port offsets
`define OFS_AUX_REG          4'h0
`define OFS_CTRL             4'h1
`define OFS_STATUS           4'h2

// control register fields
`define CTRL_IMPL64_BIT      0
`define CTRL_LEGACY_BIT      1

// status register fields
`define STAT_CR0_HI          3
`define STAT_CR0_LO          0
`define STAT_CARRY_BIT       4
`define STAT_ILLEGAL_BIT     5

// reset values
`define RST_AUX_REG          32'h0000_0000
`define RST_CTRL             2'h3
`define RST_CR0              4'h0

`endif

// >>> src/word_rotate_mask.v
// right-rotate of a word plus the matching right-shift mask

module word_rotate_mask #(
   parameter W  = 32,
   parameter AW = 5
) (
   // operand
   input  wire [W-1:0]  word_in,
   input  wire [AW-1:0] amount,
   // results
   output wire [W-1:0]  rotated,
   output wire [W-1:0]  mask
);

   // doubled word lets a plain shift express the rotation
   wire [2*W-1:0] doubled;
   wire [2*W-1:0] doubled_sh;
   wire [W-1:0]   ones;

   assign doubled    = {word_in, word_in};
   assign doubled_sh = doubled >> amount;

   // left rotate by W-N equals right rotate by N
   assign rotated = doubled_sh[W-1:0];

   // N zeros on top, W-N ones below
   assign ones = {W{1'b1}};
   assign mask = ones >> amount;

endmodule // word_rotate_mask

// >>> src/shift_right_extended_unit.v
// right-shift datapath: doubleword logical shift and extended word shifts
//
// The plain strobed port and the address map were chosen for this implementation.
`include "shift_right_ext_consts.vh"

// Behaviour
// [RULE_01] doubleword shift: 64-bit source right by low seven amount bits
// [RULE_02] bits shifted out are lost; vacated high bits fill with zero
// [RULE_03] amounts 64 to 127 give an all-zero doubleword result
// [RULE_04] doubleword record form sets condition field zero, else it holds
// [RULE_05] doubleword shift only on 64-bit implementation, else illegal
// [RULE_06] plain extended: aux gets rotated word, target rotated AND mask
// [RULE_07] mask is N zeros on top followed by 32-N ones
// [RULE_08] plain and merging extended shifts never touch the carry bit
// [RULE_09] extended record forms set condition field zero from target result
// [RULE_10] algebraic extended: rotate, store to aux, merge with sign word
// [RULE_11] sign word replicates source word sign bit across 32 positions
// [RULE_12] algebraic carry is OR of rotated AND NOT mask, ANDed with sign
// [RULE_13] merging extended: merge with previous aux, then aux gets rotated
// [RULE_14] extended shifts accepted only when older family mode is enabled
// [RULE_15] mask ones take rotated bits, mask zeros take the other operand
// [RULE_16] decode primary 31, extended 665/921/729, fields and record bit
module shift_right_extended_unit #(
   parameter DW     = 64,
   parameter WW     = 32,
   parameter ADDR_W = 4
) (
   // clock, reset, enable
   input  wire              core_clk,
   input  wire              rst_b,
   input  wire              clk_en,
   // issue from decoder and register file
   input  wire              issue_valid,
   input  wire [31:0]       instr_word,
   input  wire [DW-1:0]     source_val,
   input  wire [DW-1:0]     shift_amount_val,
   input  wire              so_in,
   // register port
   input  wire [ADDR_W-1:0] reg_addr,
   input  wire [WW-1:0]     reg_wdata,
   input  wire              reg_wr,
   input  wire              reg_rd,
   output reg  [WW-1:0]     reg_rdata_ff,
   // write-back
   output reg               done_ff,
   output reg               illegal_ff,
   output reg               target_we_ff,
   output reg  [4:0]        target_gpr_idx_ff,
   output reg  [DW-1:0]     target_value_ff,
   output reg               cr0_we_ff,
   output reg  [3:0]        condition_field_zero_ff,
   output reg               carry_we_ff,
   output reg               shift_out_flag_ff,
   output reg  [WW-1:0]     multiply_quotient_aux_reg_ff
);

   // operation codes
   localparam [2:0] OP_NONE  = 3'h0;
   localparam [2:0] OP_DSRL  = 3'h1;
   localparam [2:0] OP_PLAIN = 3'h2;
   localparam [2:0] OP_ALG   = 3'h3;
   localparam [2:0] OP_MERGE = 3'h4;

   // control and status state
   reg  [1:0]      ctrl_ff;
   reg  [1:0]      nxt_ctrl;
   reg             illegal_seen_ff;
   reg             nxt_illegal_seen;

   // decode fields
   wire [5:0]      primary;
   wire [9:0]      ext_opc;
   wire            record_flag;
   wire [4:0]      target_idx;
   wire            impl64;
   wire            legacy_en;
   reg  [2:0]      op_sel;

   // datapath wires
   wire [WW-1:0]   src_word;
   wire [WW-1:0]   rot_w;
   wire [WW-1:0]   mask_w;
   wire [WW-1:0]   sign_word;
   wire [WW-1:0]   plain_res;
   wire [WW-1:0]   alg_res;
   wire [WW-1:0]   merge_res;
   wire            alg_carry;
   wire [DW-1:0]   dsrl_res;
   wire [DW-1:0]   dsrl_shift;

   // next values of the write-back registers
   reg             nxt_done;
   reg             nxt_illegal;
   reg             nxt_target_we;
   reg  [DW-1:0]   nxt_target_value;
   reg             nxt_cr0_we;
   reg  [3:0]      nxt_cr0;
   reg             nxt_carry_we;
   reg             nxt_carry;
   reg  [WW-1:0]   nxt_aux;
   reg  [WW-1:0]   nxt_rdata;
   reg  [WW-1:0]   word_res;
   reg             use_word;

   // instruction fields, big-endian positions mapped to lsb-first
   assign primary     = instr_word[`FLD_PRIMARY_HI:`FLD_PRIMARY_LO]; // RULE_16
   assign ext_opc     = instr_word[`FLD_EXT_OPC_HI:`FLD_EXT_OPC_LO]; // RULE_16
   assign record_flag = instr_word[`FLD_RECORD]; // RULE_16
   assign target_idx  = instr_word[`FLD_TARGET_HI:`FLD_TARGET_LO]; // RULE_16

   assign impl64    = ctrl_ff[`CTRL_IMPL64_BIT];
   assign legacy_en = ctrl_ff[`CTRL_LEGACY_BIT];

   // opcode decode; unknown opcodes are simply not claimed
   always @* begin
      op_sel = OP_NONE;
      if (issue_valid && primary == `PRIMARY_OPC_SHIFTS) begin // RULE_16
         case (ext_opc)
            `EXT_OPC_DWORD_SRL: op_sel = OP_DSRL;
            `EXT_OPC_EXT_PLAIN: op_sel = OP_PLAIN; // RULE_16
            `EXT_OPC_EXT_ALG:   op_sel = OP_ALG; // RULE_16
            `EXT_OPC_EXT_MERGE: op_sel = OP_MERGE; // RULE_16
            default:            op_sel = OP_NONE;
         endcase
      end
   end

   // shared rotator and mask; amount is the low five bits of the operand
   assign src_word = source_val[WW-1:0];

   word_rotate_mask #(
      .W  (WW),
      .AW (5)
   ) word_rotate_mask_inst (
      .word_in (src_word),
      .amount  (shift_amount_val[`AMT5_HI:0]),
      .rotated (rot_w), // RULE_06
      .mask    (mask_w) // RULE_07
   );

   // sign word is all copies of the word's top bit
   assign sign_word = {WW{src_word[`WORD_SIGN_BIT]}}; // RULE_11

   // mask-controlled merges: ones pick rotated bits
   assign plain_res = rot_w & mask_w; // RULE_06
   assign alg_res   = (rot_w & mask_w) | (sign_word & ~mask_w); // RULE_15
   assign merge_res = (rot_w & mask_w) |
                      (multiply_quotient_aux_reg_ff & ~mask_w); // RULE_13

   // carry only when a negative source loses one bits
   assign alg_carry = (|(rot_w & ~mask_w)) &
                      src_word[`WORD_SIGN_BIT]; // RULE_12

   // doubleword logical shift; top amount bit forces zero
   assign dsrl_shift = source_val >> shift_amount_val[`AMT6_HI:0]; // RULE_02
   assign dsrl_res   = shift_amount_val[`AMT7_HI] ? {DW{1'b0}} // RULE_03
                                                  : dsrl_shift; // RULE_01

   // result steering and flag computation
   always @* begin
      nxt_done         = 1'b0;
      nxt_illegal      = 1'b0;
      nxt_target_we    = 1'b0;
      nxt_target_value = target_value_ff;
      nxt_cr0_we       = 1'b0;
      nxt_cr0          = condition_field_zero_ff;
      nxt_carry_we     = 1'b0;
      nxt_carry        = shift_out_flag_ff;
      nxt_aux          = multiply_quotient_aux_reg_ff;
      word_res         = {WW{1'b0}};
      use_word         = 1'b0;

      // software load of the aux register; an executing extended shift overrides it
      if (reg_wr && reg_addr == `OFS_AUX_REG) begin
         nxt_aux = reg_wdata;
      end

      case (op_sel)
         OP_DSRL: begin
            nxt_done = 1'b1;
            if (!impl64) begin
               nxt_illegal = 1'b1; // RULE_05
            end else begin
               nxt_target_we    = 1'b1;
               nxt_target_value = dsrl_res; // RULE_01
               if (record_flag) begin
                  nxt_cr0_we = 1'b1; // RULE_04
                  nxt_cr0    = cr0_of64(dsrl_res, so_in); // RULE_04
               end
            end
         end
         OP_PLAIN: begin
            nxt_done = 1'b1;
            if (!legacy_en) begin
               nxt_illegal = 1'b1; // RULE_14
            end else begin
               word_res = plain_res; // RULE_06
               use_word = 1'b1;
               nxt_aux  = rot_w; // RULE_06
            end
         end
         OP_ALG: begin
            nxt_done = 1'b1;
            if (!legacy_en) begin
               nxt_illegal = 1'b1; // RULE_14
            end else begin
               word_res     = alg_res; // RULE_10
               use_word     = 1'b1;
               nxt_aux      = rot_w; // RULE_10
               nxt_carry_we = 1'b1; // RULE_12
               nxt_carry    = alg_carry; // RULE_12
            end
         end
         OP_MERGE: begin
            nxt_done = 1'b1;
            if (!legacy_en) begin
               nxt_illegal = 1'b1; // RULE_14
            end else begin
               // merge reads the old aux value before it is replaced
               word_res = merge_res; // RULE_13
               use_word = 1'b1;
               nxt_aux  = rot_w; // RULE_13
            end
         end
         default: begin
            nxt_done = 1'b0;
         end
      endcase

      // word forms: zero upper half, carry untouched unless algebraic
      if (use_word) begin
         nxt_target_we    = 1'b1;
         nxt_target_value = {{(DW-WW){1'b0}}, word_res};
         if (record_flag) begin
            nxt_cr0_we = 1'b1; // RULE_09
            nxt_cr0    = cr0_of32(word_res, so_in); // RULE_09
         end
      end
   end

   // condition bits from a doubleword: negative, positive, zero, summary
   function [3:0] cr0_of64;
      input [DW-1:0] val;
      input          so;
      reg            neg;
      reg            zero;
      begin
         neg      = val[DW-1];
         zero     = (val == {DW{1'b0}});
         cr0_of64 = {neg, ~neg & ~zero, zero, so};
      end
   endfunction

   // same, judged on a signed word since these results are 32-bit
   function [3:0] cr0_of32;
      input [WW-1:0] val;
      input          so;
      reg            neg;
      reg            zero;
      begin
         neg      = val[WW-1];
         zero     = (val == {WW{1'b0}});
         cr0_of32 = {neg, ~neg & ~zero, zero, so};
      end
   endfunction

   // control register and sticky illegal marker
   always @* begin
      nxt_ctrl         = ctrl_ff;
      nxt_illegal_seen = illegal_seen_ff | nxt_illegal;
      if (reg_wr && reg_addr == `OFS_CTRL) begin
         nxt_ctrl = reg_wdata[1:0];
      end
      // a new illegal event wins over a clear in the same cycle
      if (reg_wr && reg_addr == `OFS_STATUS &&
          reg_wdata[`STAT_ILLEGAL_BIT]) begin
         nxt_illegal_seen = nxt_illegal;
      end
   end

   // read mux; unmapped offsets read as zero
   always @* begin
      nxt_rdata = {WW{1'b0}};
      if (reg_rd) begin
         case (reg_addr)
            `OFS_AUX_REG: nxt_rdata = multiply_quotient_aux_reg_ff;
            `OFS_CTRL:    nxt_rdata = {{(WW-2){1'b0}}, ctrl_ff};
            `OFS_STATUS:  nxt_rdata = {{(WW-6){1'b0}}, illegal_seen_ff,
                                       shift_out_flag_ff,
                                       condition_field_zero_ff};
            default:      nxt_rdata = {WW{1'b0}};
         endcase
      end
   end

   // all state; clk_en low freezes everything
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff                      <= `RST_CTRL;
         illegal_seen_ff              <= 1'b0;
         reg_rdata_ff                 <= {WW{1'b0}};
         done_ff                      <= 1'b0;
         illegal_ff                   <= 1'b0;
         target_we_ff                 <= 1'b0;
         target_gpr_idx_ff            <= 5'h00;
         target_value_ff              <= {DW{1'b0}};
         cr0_we_ff                    <= 1'b0;
         condition_field_zero_ff      <= `RST_CR0;
         carry_we_ff                  <= 1'b0;
         shift_out_flag_ff            <= 1'b0;
         multiply_quotient_aux_reg_ff <= `RST_AUX_REG;
      end else if (clk_en) begin
         ctrl_ff                      <= nxt_ctrl;
         illegal_seen_ff              <= nxt_illegal_seen;
         reg_rdata_ff                 <= nxt_rdata;
         done_ff                      <= nxt_done;
         illegal_ff                   <= nxt_illegal;
         target_we_ff                 <= nxt_target_we;
         if (nxt_done) begin
            target_gpr_idx_ff <= target_idx; // RULE_16
         end
         target_value_ff              <= nxt_target_value;
         cr0_we_ff                    <= nxt_cr0_we;
         condition_field_zero_ff      <= nxt_cr0; // RULE_04
         carry_we_ff                  <= nxt_carry_we; // RULE_08
         shift_out_flag_ff            <= nxt_carry; // RULE_08
         multiply_quotient_aux_reg_ff <= nxt_aux;
      end
   end

endmodule // shift_right_extended_unit

// >>> dv/shift_right_monitor.sv
// bound checker for the right-shift datapath ports
`include "shift_right_ext_consts.vh"
module shift_right_monitor (
   // clock and reset
   input logic        core_clk,
   input logic        rst_b,
   input logic        clk_en,
   // issue side
   input logic        issue_valid,
   input logic [31:0] instr_word,
   input logic [63:0] source_val,
   input logic [63:0] shift_amount_val,
   // write-back side
   input logic        done_ff,
   input logic        illegal_ff,
   input logic        target_we_ff,
   input logic [63:0] target_value_ff,
   input logic        cr0_we_ff,
   input logic        carry_we_ff,
   input logic        shift_out_flag_ff,
   input logic [31:0] multiply_quotient_aux_reg_ff
);
   timeunit 1ns;
   timeprecision 1ps;
   // reference rotate, mask and merges taken straight from the inputs
   wire [9:0]  ext_w = instr_word[10:1];
   wire [4:0]  n_w   = shift_amount_val[4:0];
   wire [63:0] dbl_w = {source_val[31:0], source_val[31:0]} >> n_w;
   wire [31:0] rot_w = dbl_w[31:0];
   wire [31:0] msk_w = 32'hffff_ffff >> n_w;
   wire [31:0] alg_w = rot_w & msk_w | {32{source_val[31]}} & ~msk_w;
   wire [31:0] mrg_w = rot_w & msk_w | multiply_quotient_aux_reg_ff & ~msk_w;
   wire        cry_w = |(rot_w & ~msk_w) & source_val[31];
   wire [63:0] srd_w = source_val >> shift_amount_val[6:0];
   wire        rc_w  = instr_word[0];
   wire        go_w  = clk_en && issue_valid &&
                       instr_word[31:26] == `PRIMARY_OPC_SHIFTS;
   wire        srd_q = go_w && ext_w == `EXT_OPC_DWORD_SRL;
   wire        pln_q = go_w && ext_w == `EXT_OPC_EXT_PLAIN;
   wire        alg_q = go_w && ext_w == `EXT_OPC_EXT_ALG;
   wire        mrg_q = go_w && ext_w == `EXT_OPC_EXT_MERGE;
   wire        ext_q = pln_q || alg_q || mrg_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // taken, then answered without refusal
   sequence s_ok(q);
      q ##1 !illegal_ff;
   endsequence
   property p_answer;
      (srd_q || ext_q) |=> done_ff;
   endproperty
   a_answer: assert property (p_answer)
      else $error("issue unanswered");
   property p_ignore;
      clk_en && !(srd_q || ext_q) |=> !done_ff;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("stray done");
   property p_refuse;
      illegal_ff |-> done_ff && !target_we_ff && !cr0_we_ff && !carry_we_ff;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("refused op wrote");
   property p_srd;
      s_ok(srd_q) |-> target_we_ff && !carry_we_ff &&
         target_value_ff == $past(srd_w);
   endproperty
   a_srd: assert property (p_srd)
      else $error("doubleword result");
   property p_plain;
      s_ok(pln_q) |-> !carry_we_ff &&
         target_value_ff == {32'h0, $past(rot_w) & $past(msk_w)};
   endproperty
   a_plain: assert property (p_plain)
      else $error("plain result");
   property p_alg;
      s_ok(alg_q) |-> carry_we_ff && shift_out_flag_ff == $past(cry_w) &&
         target_value_ff[31:0] == $past(alg_w);
   endproperty
   a_alg: assert property (p_alg)
      else $error("algebraic result");
   property p_merge;
      s_ok(mrg_q) |-> !carry_we_ff && target_value_ff[31:0] == $past(mrg_w);
   endproperty
   a_merge: assert property (p_merge)
      else $error("merge result");
   property p_aux;
      s_ok(ext_q) |-> multiply_quotient_aux_reg_ff == $past(rot_w);
   endproperty
   a_aux: assert property (p_aux)
      else $error("aux not rotated word");
   property p_rec;
      s_ok(srd_q || ext_q) |-> cr0_we_ff == $past(rc_w);
   endproperty
   a_rec: assert property (p_rec)
      else $error("record write");
endmodule // shift_right_monitor

bind shift_right_extended_unit shift_right_monitor shift_right_monitor_inst (
   .core_clk, .rst_b, .clk_en, .issue_valid, .instr_word, .source_val,
   .shift_amount_val, .done_ff, .illegal_ff, .target_we_ff, .target_value_ff,
   .cr0_we_ff, .carry_we_ff, .shift_out_flag_ff, .multiply_quotient_aux_reg_ff
);

// >>> dv/operand_feeder.sv
// decoder and register-file stand-in for the right-shift datapath
`include "shift_right_ext_consts.vh"
module operand_feeder (
   // clock
   input  logic        core_clk,
   // request from the bench
   input  logic        req,
   input  logic [9:0]  ext_opc,
   input  logic        record_flag,
   input  logic [4:0]  target_gpr,
   input  logic [63:0] src_in,
   input  logic [63:0] amt_in,
   // issue toward the datapath
   output logic        issue_valid = 1'b0,
   output logic [31:0] instr_word = 32'h0,
   output logic [63:0] source_val = 64'h0,
   output logic [63:0] shift_amount_val = 64'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   // one issue per request; idle operands flip so stale data is never reused
   always @(posedge core_clk) begin
      issue_valid      <= req;
      instr_word       <= {`PRIMARY_OPC_SHIFTS, 5'h03, target_gpr, 5'h05,
                           ext_opc, record_flag};
      source_val       <= req ? src_in : ~source_val;
      shift_amount_val <= req ? amt_in : ~shift_amount_val;
   end
endmodule // operand_feeder

// >>> dv/shift_right_extended_unit_tb_top.sv
// self-checking bench for the right-shift datapath
`include "shift_right_ext_consts.vh"
module shift_right_extended_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] SR = `EXT_OPC_DWORD_SRL;
   localparam logic [9:0] PL = `EXT_OPC_EXT_PLAIN;
   localparam logic [9:0] AL = `EXT_OPC_EXT_ALG;
   localparam logic [9:0] MG = `EXT_OPC_EXT_MERGE;
   typedef struct {logic [9:0] op; logic rc; logic [63:0] s, a;} row_t;
   // bench-driven inputs
   logic        core_clk  = 1'b0;
   logic        rst_b     = 1'b0;
   logic        clk_en    = 1'b1;
   logic        req       = 1'b0;
   logic [9:0]  op        = 10'h000;
   logic        rc        = 1'b0;
   logic [63:0] s         = 64'h0;
   logic [63:0] a         = 64'h0;
   logic        so_in     = 1'b0;
   logic [3:0]  reg_addr  = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   // observed
   logic        issue_valid, done_ff, illegal_ff, target_we_ff;
   logic        cr0_we_ff, carry_we_ff, shift_out_flag_ff;
   logic [31:0] instr_word, reg_rdata_ff, multiply_quotient_aux_reg_ff;
   logic [63:0] source_val, shift_amount_val, target_value_ff;
   logic [4:0]  target_gpr_idx_ff;
   logic [3:0]  condition_field_zero_ff;
   logic [31:0] aux_e  = 32'h0;
   logic [3:0]  cr_e   = 4'h0;
   logic        cy_e   = 1'b0;
   int          errors = 0;
   int          checks = 0;
   // word ops first, then doubleword amounts at and past the edges
   row_t rows[13] = '{
      '{PL, 1'b0, 64'h9000_3000, 64'hc}, '{PL, 1'b1, 64'hb004_3000, 64'hf},
      '{PL, 1'b1, 64'h8000_0001, 64'h0}, '{PL, 1'b0, 64'hffff_ffff, 64'h7f},
      '{AL, 1'b0, 64'h9000_3000, 64'h4}, '{AL, 1'b1, 64'hb004_3000, 64'h4},
      '{AL, 1'b1, 64'h7000_000f, 64'h4}, '{AL, 1'b1, 64'h8000_000f, 64'h4},
      '{MG, 1'b1, 64'h9000_300f, 64'h4},
      '{SR, 1'b1, 64'h8000_0000_0000_0001, 64'h3f},
      '{SR, 1'b1, 64'h8000_0000_0000_0000, 64'h80},
      '{SR, 1'b1, 64'hffff_ffff_ffff_ffff, 64'h40},
      '{SR, 1'b0, 64'hffff_ffff_ffff_ffff, 64'h7f}};

   always #12.5 core_clk = ~core_clk;

   operand_feeder operand_feeder_inst (.core_clk, .req, .ext_opc(op),
      .record_flag(rc), .target_gpr(s[4:0]), .src_in(s), .amt_in(a),
      .issue_valid, .instr_word, .source_val, .shift_amount_val);

   shift_right_extended_unit shift_right_extended_unit_inst (.core_clk,
      .rst_b, .clk_en, .issue_valid, .instr_word, .source_val,
      .shift_amount_val, .so_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_ff, .done_ff, .illegal_ff, .target_we_ff,
      .target_gpr_idx_ff, .target_value_ff, .cr0_we_ff,
      .condition_field_zero_ff, .carry_we_ff, .shift_out_flag_ff,
      .multiply_quotient_aux_reg_ff);

   task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
      checks++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         errors++;
      end
   endtask

   task complete_run;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task do_reset;
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
   endtask

   task automatic wr(logic [3:0] ad, logic [31:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= ad;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(logic [3:0] ad, output logic [31:0] v);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= ad;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata_ff;
   endtask

   // word op reference: {carry, rotated, result}
   function automatic logic [64:0] model(row_t r, logic [31:0] q);
      logic [63:0] d;
      logic [31:0] m, o;
      d = {r.s[31:0], r.s[31:0]} >> r.a[4:0];
      m = 32'hffff_ffff >> r.a[4:0];
      o = r.op == AL ? {32{r.s[31]}} : r.op == MG ? q : 32'h0;
      model = {|(d[31:0] & ~m) & r.s[31], d[31:0], d[31:0] & m | o & ~m};
   endfunction

   // k: 0 executes, 1 refused, 2 not recognised
   task automatic run(row_t r, int k);
      logic [64:0]        e;
      logic [63:0]        t;
      logic signed [63:0] v;
      e = model(r, aux_e);
      t = r.op != SR ? {32'h0, e[31:0]} : r.s >> r.a[6:0];
      v = r.op != SR ? {{32{e[31]}}, e[31:0]} : t;
      @(posedge core_clk);
      req   <= 1'b1;
      op    <= r.op;
      rc    <= r.rc;
      s     <= r.s;
      a     <= r.a;
      so_in <= r.a[0];
      @(posedge core_clk);
      req <= 1'b0;
      @(posedge core_clk);
      #1;
      if (k == 0 && r.op != SR)
         aux_e = e[63:32];
      // carry and condition bits hold unless this op may write them
      if (k == 0 && r.op == AL)
         cy_e = e[64];
      if (k == 0 && r.rc)
         cr_e = {v < 0, v > 0, v == 0, r.a[0]};
      chk("done", k != 2, done_ff);
      chk("illegal", k == 1, illegal_ff);
      chk("target_we", k == 0, target_we_ff);
      chk("aux", aux_e, multiply_quotient_aux_reg_ff);
      if (k == 0) begin
         chk("value", t, target_value_ff);
         chk("index", r.s[4:0], target_gpr_idx_ff);
         chk("cr0_we", r.rc, cr0_we_ff);
         chk("carry_we", r.op == AL, carry_we_ff);
      end
      chk("cr0", cr_e, condition_field_zero_ff);
      chk("carry", cy_e, shift_out_flag_ff);
   endtask

   initial begin
      logic [31:0] d;
      do_reset;
      foreach (rows[i])
         run(rows[i], 0);
      // preset aux, then merge against it
      wr(`OFS_AUX_REG, 32'h1111_1111);
      aux_e = 32'h1111_1111;
      rd(`OFS_AUX_REG, d);
      chk("aux_rd", 32'h1111_1111, d);
      run('{MG, 1'b1, 64'h9000_300f, 64'h4}, 0);
      rd(4'h7, d);
      chk("unmapped", 32'h0, d);
      // both modes off: doubleword and algebraic ops refused, sticky flag set then cleared
      wr(`OFS_CTRL, 32'h0);
      run('{SR, 1'b1, 64'hff, 64'h1}, 1);
      run('{AL, 1'b1, 64'hff, 64'h1}, 1);
      rd(`OFS_STATUS, d);
      chk("sticky", 1'b1, d[5]);
      wr(`OFS_STATUS, 32'h20);
      rd(`OFS_STATUS, d);
      chk("cleared", 1'b0, d[5]);
      run('{10'h318, 1'b1, 64'hff, 64'h1}, 2);
      // enable low: the issue is not taken, nothing moves
      @(posedge core_clk) clk_en <= 1'b0;
      run('{PL, 1'b1, 64'hff, 64'h1}, 2);
      @(posedge core_clk) clk_en <= 1'b1;
      // sticky flag, carry and cr0 all set so reset has work to do
      run('{SR, 1'b1, 64'hff, 64'h1}, 1);
      // second reset restores the register defaults
      do_reset;
      aux_e = `RST_AUX_REG;
      cr_e  = `RST_CR0;
      cy_e  = 1'b0;
      rd(`OFS_AUX_REG, d);
      chk("aux_rst", `RST_AUX_REG, d);
      rd(`OFS_CTRL, d);
      chk("ctrl_rst", {30'h0, `RST_CTRL}, d);
      rd(`OFS_STATUS, d);
      chk("stat_rst", 32'h0, d);
      run('{PL, 1'b0, 64'h1, 64'h1}, 0);
      complete_run;
   end

   // hang guard, far beyond the roughly 110 cycles the run needs
   initial begin
      repeat (3000) @(posedge core_clk);
      errors++;
      complete_run;
   end
endmodule // shift_right_extended_unit_tb_top
